// ---- design/rfic_regs.svh ----
// reset controller constants: timing counts, reset values, widths
`ifndef RFIC_REGS_SVH
`define RFIC_REGS_SVH

// clock and reset hold timing
`define RFIC_CLK_PERIOD_NS 20
`define RFIC_RST_HOLD_NS 200
// least time, rounded up to whole cycles
`define RFIC_RST_HOLD_CYC ((`RFIC_RST_HOLD_NS + `RFIC_CLK_PERIOD_NS - 1) / `RFIC_CLK_PERIOD_NS)
`define RFIC_CNT_W 4

// stack pointer width and initial values
`define RFIC_SP_W 3
`define RFIC_SP_TOP 3'h7
`define RFIC_SP_ZERO 3'h0

// flag reset values
`define RFIC_TIMEOUT_RST 1'h0
`define RFIC_POWERDOWN_RST 1'h0
`define RFIC_LV_CAUSE_RST 1'h0

`endif

// ---- design/rfic_pkg.sv ----
// reset controller types: sequencer states and reset causes
package rfic_pkg;

  // gray along run -> full -> run; warm is the side branch
  typedef enum logic [1:0]
  {
    ST_RUN  = 2'h0,
    ST_FULL = 2'h1,
    ST_WARM = 2'h2
  } rfic_state_type;

  typedef enum logic [1:0]
  {
    CS_POR      = 2'h0,
    CS_LVR      = 2'h1,
    CS_WDT_RUN  = 2'h2,
    CS_WDT_IDLE = 2'h3
  } rfic_cause_type;

endpackage : rfic_pkg

// ---- design/rfic_sync2.sv ----
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none

module rfic_sync2
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // level in and out
  input wire logic i_async,
  output logic o_sync
);

  logic meta_ff;

  // first stage is read only by the second
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_ff <= 1'h0;
      o_sync <= 1'h0;
    end
    else
    begin
      meta_ff <= i_async;
      o_sync <= meta_ff;
    end
  end

endmodule : rfic_sync2

`default_nettype wire

// ---- design/rfic_top.sv ----
// reset sequencer: cause tracking, status flags and init strobes
// Summary of operation
// - A watchdog time-out in fast or slow mode causes a full reset and sets the time-out flag.
// - A watchdog time-out in sleep or idle clears only program counter and stack pointer.
// - A watchdog time-out in sleep or idle sets both time-out and power-down flags.
// - Both flags live in the status word, follow sleep entry and watchdog events, and power-on clears them.
// - A low-voltage reset in fast or slow mode leaves both flags as they were.
// - After power-on every interrupt source stays disabled until software enables it.
// - After power-on the watchdog counter is cleared and then counts at once.
// - After power-on all timers are stopped.
// - After power-on every general I/O pin is an input.
// - After power-on the stack pointer points at the top of the stack.
// - Registers initialise on power-on and run-mode watchdog reset, while a sleep watchdog reset clears only the program counter low byte and the stack pointer.
// - A low-voltage condition outside sleep and idle resets the device and sets a cause flag that only software or power-on clears.
`timescale 1ns/10ps
`default_nettype none
`include "rfic_regs.svh"

module rfic_top
(
  // clock and power-on reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // events from watchdog, supply monitor and core
  input wire logic i_wdt_timeout,
  input wire logic i_low_voltage,
  input wire logic i_sleep_mode,
  input wire logic i_sleep_enter,
  input wire logic i_wdt_clr,
  // software controls
  input wire logic i_lv_cause_clr,
  input wire logic i_int_sw_enable,
  // status flags
  output logic o_timeout_flag,
  output logic o_powerdown_flag,
  output logic o_low_voltage_reset_cause,
  // reset strobes to core and peripherals
  output logic o_regs_init,
  output logic o_pc_clear,
  output logic o_sp_load,
  output logic [`RFIC_SP_W-1:0] o_sp_value,
  output logic o_wdt_clear,
  output logic o_timer_stop,
  output logic o_io_input,
  output logic o_int_disable,
  output rfic_pkg::rfic_state_type o_state
);

  import rfic_pkg::*;

  localparam logic [`RFIC_CNT_W-1:0] HOLD_LAST =
    `RFIC_CNT_W'(`RFIC_RST_HOLD_CYC - 1);

  rfic_state_type state_ff, nxt_state;
  rfic_cause_type cause_ff, nxt_cause;
  logic [`RFIC_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic timeout_ff, nxt_timeout;
  logic powerdown_ff, nxt_powerdown;
  logic lv_cause_ff, nxt_lv_cause;
  logic int_dis_ff, nxt_int_dis;
  logic lv_sync;
  wire in_run;
  wire wdt_run_evt;
  wire wdt_idle_evt;
  wire lvr_evt;
  wire lv_hold;
  wire release_evt;

  // supply monitor is analog and asynchronous to the clock
  rfic_sync2 u_lv_sync
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_low_voltage),
    .o_sync(lv_sync)
  );

  // event decode; events only count while the core runs
  assign in_run = (state_ff == ST_RUN);
  assign wdt_run_evt = in_run && i_wdt_timeout && !i_sleep_mode;
  assign wdt_idle_evt = in_run && i_wdt_timeout && i_sleep_mode;
  // the supply monitor is off in sleep and idle
  assign lvr_evt = in_run && lv_sync && !i_sleep_mode;
  // a lasting low supply keeps the full reset applied
  assign lv_hold = (state_ff == ST_FULL) && (cause_ff == CS_LVR) && lv_sync;
  assign release_evt = !in_run && (cnt_ff == HOLD_LAST) && !lv_hold;

  // sequencer next state; low voltage beats watchdog in the same cycle
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cause = cause_ff;
    case (state_ff)
      ST_RUN:
      begin
        if (lvr_evt)
        begin
          nxt_state = ST_FULL;
          nxt_cause = CS_LVR;
        end
        else if (wdt_run_evt)
        begin
          nxt_state = ST_FULL;
          nxt_cause = CS_WDT_RUN;
        end
        else if (wdt_idle_evt)
        begin
          nxt_state = ST_WARM;
          nxt_cause = CS_WDT_IDLE;
        end
      end
      ST_FULL, ST_WARM:
      begin
        if (release_evt)
          nxt_state = ST_RUN;
      end
      default:
        nxt_state = ST_FULL;
    endcase
  end

  // hold counter restarts on entry and while low voltage persists
  assign nxt_cnt = (in_run || lv_hold) ? `RFIC_CNT_W'h0 :
                   (release_evt ? `RFIC_CNT_W'h0 : cnt_ff + `RFIC_CNT_W'h1);

  // status flags; hardware sets win over clears in the same cycle
  assign nxt_timeout =
    (release_evt && (cause_ff == CS_WDT_RUN)) ? 1'h1 :
    (release_evt && (cause_ff == CS_WDT_IDLE)) ? 1'h1 :
    (in_run && (i_sleep_enter || i_wdt_clr)) ? 1'h0 :
    timeout_ff;
  assign nxt_powerdown =
    (release_evt && (cause_ff == CS_WDT_IDLE)) ? 1'h1 :
    (in_run && i_sleep_enter) ? 1'h1 :
    (in_run && i_wdt_clr) ? 1'h0 :
    powerdown_ff;
  assign nxt_lv_cause = lvr_evt ? 1'h1 :
                        (i_lv_cause_clr ? 1'h0 : lv_cause_ff);

  // interrupts stay masked after a full reset until software opens them
  assign nxt_int_dis = (nxt_state == ST_FULL) ? 1'h1 :
                       ((in_run && i_int_sw_enable) ? 1'h0 : int_dis_ff);

  // power-on enters a full reset with cleared flags
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_ff <= ST_FULL;
      cause_ff <= CS_POR;
      cnt_ff <= `RFIC_CNT_W'h0;
      timeout_ff <= `RFIC_TIMEOUT_RST;
      powerdown_ff <= `RFIC_POWERDOWN_RST;
      lv_cause_ff <= `RFIC_LV_CAUSE_RST;
      int_dis_ff <= 1'h1;
    end
    else
    begin
      state_ff <= nxt_state;
      cause_ff <= nxt_cause;
      cnt_ff <= nxt_cnt;
      timeout_ff <= nxt_timeout;
      powerdown_ff <= nxt_powerdown;
      lv_cause_ff <= nxt_lv_cause;
      int_dis_ff <= nxt_int_dis;
    end
  end

  // reset strobes registered from the next state so they drop at release
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_regs_init <= 1'h1;
      o_pc_clear <= 1'h1;
      o_sp_load <= 1'h1;
      o_sp_value <= `RFIC_SP_TOP;
      o_wdt_clear <= 1'h1;
      o_timer_stop <= 1'h1;
      o_io_input <= 1'h1;
    end
    else
    begin
      o_regs_init <= (nxt_state == ST_FULL);
      o_pc_clear <= (nxt_state != ST_RUN);
      o_sp_load <= (nxt_state != ST_RUN);
      o_sp_value <= (nxt_state == ST_WARM) ? `RFIC_SP_ZERO : `RFIC_SP_TOP;
      o_wdt_clear <= (nxt_state == ST_FULL);
      o_timer_stop <= (nxt_state == ST_FULL);
      o_io_input <= (nxt_state == ST_FULL);
    end
  end

  // flag and state outputs come straight from their flops
  assign o_timeout_flag = timeout_ff;
  assign o_powerdown_flag = powerdown_ff;
  assign o_low_voltage_reset_cause = lv_cause_ff;
  assign o_int_disable = int_dis_ff;
  assign o_state = state_ff;

  // checks on the sequencing
  a_wdt_run_reset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wdt_run_evt && !lvr_evt |=> o_regs_init [*8])
    else $error("run watchdog did not give full reset");
  a_wdt_run_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wdt_run_evt && !lvr_evt |-> ##11 (o_timeout_flag && !o_regs_init))
    else $error("time-out flag not set after run watchdog");
  a_wdt_idle_warm: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wdt_idle_evt |=> (o_pc_clear && !o_regs_init && o_sp_value == 3'h0) [*8])
    else $error("sleep watchdog touched more than pc and sp");
  a_wdt_idle_flags: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wdt_idle_evt |-> ##11 (o_timeout_flag && o_powerdown_flag && !o_pc_clear))
    else $error("sleep watchdog flags wrong");
  a_por_flags_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_regs_init && cause_ff == CS_POR) |-> (!o_timeout_flag && !o_powerdown_flag))
    else $error("flags not clear during power-on reset");
  a_lvr_flags_kept: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    lvr_evt |-> ##11 (o_timeout_flag == $past(o_timeout_flag, 11)
      && o_powerdown_flag == $past(o_powerdown_flag, 11)))
    else $error("low-voltage reset changed status flags");
  a_int_stay_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $fell(o_regs_init) |-> o_int_disable [*2])
    else $error("interrupts enabled without software");
  a_wdt_starts: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $fell(o_regs_init) |-> (!o_wdt_clear && $past(o_wdt_clear)))
    else $error("watchdog clear not released with reset");
  a_full_init_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_regs_init |-> (o_timer_stop && o_io_input && o_sp_value == 3'h7))
    else $error("timers, ports or stack not initialised");
  a_lvr_cause_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    lvr_evt |=> (o_low_voltage_reset_cause && o_regs_init))
    else $error("low-voltage cause flag not set");
  a_release_edge: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ($fell(o_regs_init) && $past(cause_ff) == CS_WDT_RUN) |-> o_timeout_flag)
    else $error("flag update not aligned with release");

endmodule : rfic_top

`default_nettype wire

// ---- bench/rfic_core_model.sv ----
// core-side model: program counter, stack pointer and one scratch register
`timescale 1ns/10ps
`default_nettype none
`include "rfic_regs.svh"

module rfic_core_model
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // strobes from the sequencer
  input wire logic i_regs_init,
  input wire logic i_pc_clear,
  input wire logic i_sp_load,
  input wire logic [`RFIC_SP_W-1:0] i_sp_value,
  // scratch write from software
  input wire logic i_wr,
  input wire logic [7:0] i_data,
  // observed state
  output logic [7:0] o_pc_low,
  output logic [`RFIC_SP_W-1:0] o_sp,
  output logic [7:0] o_scratch
);
  // pc runs freely so that a missed clear shows at release
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) o_pc_low <= 8'h5a;
    else if (i_pc_clear) o_pc_low <= 8'h00;
    else o_pc_low <= o_pc_low + 8'h01;
  // stack pointer follows the load strobe only
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) o_sp <= 3'h2;
    else if (i_sp_load) o_sp <= i_sp_value;
  // scratch register is wiped only by a full init
  always_ff @(posedge i_clk)
    if (i_regs_init) o_scratch <= 8'h00;
    else if (i_wr) o_scratch <= i_data;
endmodule : rfic_core_model
`default_nettype wire

// ---- bench/rfic_top_bench.sv ----
// self-checking bench for the reset sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module rfic_top_bench;
  import rfic_pkg::*;
  typedef struct packed {logic [2:0] f; logic [6:0] s; logic [2:0] sp;
    logic [4:0] n;} rfic_note_type;
  logic i_clk = 0, i_reset_n = 0, wdt = 0, lv = 0, slm = 0, sle = 0;
  logic wclr = 0, lvc = 0, ien = 0, wr = 0;
  logic [7:0] data = 8'h00;
  wire logic tmo, pd, lvf, ri, pcc, spl, wc, ts, io, id;
  wire logic [2:0] spv, sp;
  wire logic [7:0] pc, scr;
  rfic_state_type st;
  rfic_note_type q[$], cap;
  int failures = 0, tests_run = 0;
  int lvw = 0;
  always #10 i_clk = ~i_clk;
  rfic_top rfic_top_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_wdt_timeout(wdt), .i_low_voltage(lv), .i_sleep_mode(slm),
    .i_sleep_enter(sle), .i_wdt_clr(wclr), .i_lv_cause_clr(lvc),
    .i_int_sw_enable(ien), .o_timeout_flag(tmo), .o_powerdown_flag(pd),
    .o_low_voltage_reset_cause(lvf), .o_regs_init(ri), .o_pc_clear(pcc),
    .o_sp_load(spl), .o_sp_value(spv), .o_wdt_clear(wc), .o_timer_stop(ts),
    .o_io_input(io), .o_int_disable(id), .o_state(st));
  rfic_core_model rfic_core_model_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_regs_init(ri), .i_pc_clear(pcc), .i_sp_load(spl), .i_sp_value(spv),
    .i_wr(wr), .i_data(data), .o_pc_low(pc), .o_sp(sp), .o_scratch(scr));

  // watcher: records the first reset cycle, compares at the release edge
  always @(posedge i_clk)
  begin
    #1;
    if (!i_reset_n) cap.n = 0;
    else if (st !== ST_RUN)
    begin
      if (cap.n == 0) cap = {3'h0, {ri, wc, ts, io, id, pcc, spl}, spv, 5'h0};
      cap.n++;
    end
    else if (cap.n != 0)
    begin
      cap.f = {tmo, pd, lvf};
      if (q.size() == 0) `CHK(cap, 16'h0)
      else
      begin
        if (q[0].n == 0) cap.n = 0;
        `CHK(cap, q[0])
        `CHK({pc, sp}, {8'h00, q[0].sp})
        void'(q.pop_front());
      end
      cap.n = 0;
    end
  end

  // one-cycle pulse launched on the falling edge
  task automatic pulse(ref logic s);
    @(negedge i_clk) s = 1;
    @(negedge i_clk) s = 0;
  endtask : pulse

  // random events while a reset holds; all of them must be ignored
  task noise;
    repeat (8)
    begin
      @(negedge i_clk) {wdt, sle, wclr, ien} = 4'($urandom);
    end
    @(negedge i_clk) {wdt, sle, wclr, ien} = 4'h0;
  endtask : noise

  // bounded wait until every note has been answered
  task settle;
    for (int i = 0; i < 60 && q.size() > 0; i++) @(posedge i_clk);
    repeat (2 + $urandom % 4) @(negedge i_clk);
    `CHK(q.size(), 0)
  endtask : settle

  // power-on reset: 16 cycles low, then settle until the note is answered
  task por;
    @(negedge i_clk) i_reset_n = 0;
    repeat (16) @(negedge i_clk);
    q.push_back({3'h0, 7'h7f, 3'h7, 5'd9});
    i_reset_n = 1;
    settle();
  endtask : por

  task summarize;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge i_clk);
    failures++;
    summarize();
  end

  initial
  begin
    void'($urandom(46440));
    por();
    `CHK({tmo, pd, lvf, id}, 4'h1)
    q.push_back({3'h4, 7'h7f, 3'h7, 5'd10});
    pulse(wdt);
    noise();
    settle();
    `CHK(id, 1'b1)
    pulse(ien);
    @(negedge i_clk) data = 8'($urandom);
    pulse(wr);
    pulse(sle);
    `CHK({tmo, pd, id}, 3'h2)
    @(negedge i_clk) slm = 1;
    q.push_back({3'h6, 7'h03, 3'h0, 5'd10});
    pulse(wdt);
    noise();
    settle();
    `CHK(scr, data)
    slm = 0;
    pulse(wclr);
    pulse(sle);
    `CHK({tmo, pd}, 2'h1)
    // low supply for lvw cycles: 2 sync stages, then 10 hold cycles
    lvw = 2 + $urandom % 4;
    q.push_back({3'h3, 7'h7f, 3'h7, 5'(lvw + 9)});
    @(negedge i_clk) lv = 1;
    repeat (lvw) @(negedge i_clk);
    lv = 0;
    settle();
    `CHK(scr, 8'h00)
    pulse(lvc);
    `CHK(lvf, 1'b0)
    slm = 1;
    lv = 1;
    repeat (5) @(negedge i_clk);
    lv = 0;
    settle();
    `CHK({st, lvf}, 3'h0)
    slm = 0;
    por();
    `CHK({tmo, pd, lvf}, 3'h0)
    summarize();
  end
endmodule : rfic_top_bench
`default_nettype wire
